// file: core/frpoc_pkg.sv
package frpoc_pkg;

	// clock and time base
	localparam int unsigned CLK_PERIOD_PS = 5000;
	localparam int unsigned CYC_PER_US = 1000000 / CLK_PERIOD_PS;
	localparam int unsigned CYC_PER_MS = 1000 * CYC_PER_US;

	// times as printed, in their own units
	localparam int unsigned RESET_LOW_PULSE_MIN_US = 10;
	localparam int unsigned RESET_TO_SELECT_DELAY_US = 10;
	localparam int unsigned POWER_ON_RESET_RECOVERY_US = 35;
	localparam int unsigned REC_DECODE_US = 40;
	localparam int unsigned REC_READ_US = 35;
	localparam int unsigned REC_PROGRAM_US = 310;
	localparam int unsigned REC_SMALL_SECTOR_MS = 12;
	localparam int unsigned REC_BLOCK_MS = 25;
	localparam int unsigned REC_CHIP_MS = 100;
	localparam int unsigned REC_STATUS_WRITE_MS = 40;
	localparam int unsigned SUPPLY_TO_SELECT_DELAY_US = 100;

	// the same times in clock cycles
	localparam int unsigned RESET_LOW_PULSE_MIN_CYC = RESET_LOW_PULSE_MIN_US * CYC_PER_US;
	localparam int unsigned RESET_TO_SELECT_DELAY_CYC = RESET_TO_SELECT_DELAY_US * CYC_PER_US;
	localparam int unsigned POWER_ON_RESET_RECOVERY_CYC = POWER_ON_RESET_RECOVERY_US * CYC_PER_US;
	localparam int unsigned REC_DECODE_CYC = REC_DECODE_US * CYC_PER_US;
	localparam int unsigned REC_READ_CYC = REC_READ_US * CYC_PER_US;
	localparam int unsigned REC_PROGRAM_CYC = REC_PROGRAM_US * CYC_PER_US;
	localparam int unsigned REC_SMALL_SECTOR_CYC = REC_SMALL_SECTOR_MS * CYC_PER_MS;
	localparam int unsigned REC_BLOCK_CYC = REC_BLOCK_MS * CYC_PER_MS;
	localparam int unsigned REC_CHIP_CYC = REC_CHIP_MS * CYC_PER_MS;
	localparam int unsigned REC_STATUS_WRITE_CYC = REC_STATUS_WRITE_MS * CYC_PER_MS;
	localparam int unsigned SUPPLY_TO_SELECT_DELAY_CYC = SUPPLY_TO_SELECT_DELAY_US * CYC_PER_US;

	// timer width covers the longest recovery
	localparam int unsigned TMR_W = 25;
	typedef logic [TMR_W-1:0] frpoc_cnt_t;

	// register map
	localparam int unsigned ADDR_W = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_RST_COUNT = 8'h08;
	localparam int unsigned CTRL_FORCE_BIT = 0;
	localparam int unsigned STAT_STATE_LSB = 0;
	localparam int unsigned STAT_KIND_LSB = 4;
	localparam int unsigned STAT_SHORT_BIT = 8;
	localparam int unsigned STAT_EARLY_BIT = 9;
	localparam int unsigned STAT_READY_BIT = 10;
	localparam int unsigned RST_COUNT_W = 16;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'h0;

	typedef enum logic [2:0] {ST_POR, ST_POWERUP, ST_READY, ST_RESET, ST_RECOVER} frpoc_state_t;

	typedef enum logic [3:0] {
		K_IDLE, K_DECODE, K_READ, K_PROGRAM, K_SMALL_ERASE,
		K_HALF_BLOCK, K_LARGE_BLOCK, K_CHIP_ERASE, K_STATUS_WRITE
	} frpoc_kind_t;

	// operation in progress, reported by the flash core
	typedef struct packed {
		logic erase_suspended;
		frpoc_kind_t suspended_kind;
		frpoc_kind_t kind;
	} frpoc_op_t;

	// controls handed to the flash core
	typedef struct packed {
		logic core_rst;
		logic abort;
		logic so_allow;
		logic low_power;
		logic read_ok;
		logic write_ok;
	} frpoc_ctl_t;

endpackage

// file: core/frpoc_timer.sv
`timescale 1ns/1ps
module frpoc_timer (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// load and status
	input wire logic load,
	input wire frpoc_pkg::frpoc_cnt_t load_val,
	output logic done
);
	frpoc_pkg::frpoc_cnt_t cnt_q;

	// counts down to zero, reload wins
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_q <= '0;
		end else if (load) begin
			cnt_q <= load_val;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

	assign done = (cnt_q == '0) & ~load;
endmodule // frpoc_timer

// file: core/frpoc_top.sv
// How it works
// - reset low ten microseconds is full reset
// - after reset: standby, volatile bits cleared, 3-byte
// - reset aborts running program or erase
// - during reset output off, minimal activity
// - recovery 40/35/310 us by interrupted operation
// - erase recovery 12, 25, 100 ms
// - status write 40 ms, power-on 35 us
// - suspended erase sets the recovery time
// - power-up enters standby, write latch cleared
// - below supply threshold logic held, commands ignored
// - reads accepted after start-up delay
`timescale 1ns/1ps
module frpoc_top #(
	parameter int unsigned POR_REC_CYC = frpoc_pkg::POWER_ON_RESET_RECOVERY_CYC,
	parameter int unsigned REC_DECODE_CYC = frpoc_pkg::REC_DECODE_CYC,
	parameter int unsigned REC_READ_CYC = frpoc_pkg::REC_READ_CYC,
	parameter int unsigned REC_PROGRAM_CYC = frpoc_pkg::REC_PROGRAM_CYC,
	parameter int unsigned REC_SMALL_CYC = frpoc_pkg::REC_SMALL_SECTOR_CYC,
	parameter int unsigned REC_BLOCK_CYC = frpoc_pkg::REC_BLOCK_CYC,
	parameter int unsigned REC_CHIP_CYC = frpoc_pkg::REC_CHIP_CYC,
	parameter int unsigned REC_STATUS_CYC = frpoc_pkg::REC_STATUS_WRITE_CYC,
	parameter int unsigned SUPPLY_SEL_CYC = frpoc_pkg::SUPPLY_TO_SELECT_DELAY_CYC
) (
	// clock and reset
	input wire logic CLK,
	input wire logic SYS_RST,
	// pins
	input wire logic RESET_N,
	input wire logic CS_N,
	input wire logic SUPPLY_OK,
	// flash core
	input wire frpoc_pkg::frpoc_op_t OP_STAT,
	output frpoc_pkg::frpoc_ctl_t CTL,
	// ahb-lite slave
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP
);
	frpoc_pkg::frpoc_state_t state_q;
	frpoc_pkg::frpoc_kind_t kind_q;
	logic [2:0] sync1_q;
	logic [2:0] sync2_q;
	logic rst_pin_low;
	logic cs_low;
	logic supply_ok_s;
	logic rst_low;
	logic rst_low_q;
	logic ctrl_force_q;
	logic short_q;
	logic early_q;
	logic abort_q;
	logic [frpoc_pkg::RST_COUNT_W-1:0] rst_cnt_q;
	logic pulse_load;
	logic pulse_done;
	logic tmr_load;
	frpoc_pkg::frpoc_cnt_t tmr_val;
	logic tmr_done;
	frpoc_pkg::frpoc_cnt_t req_cyc;
	frpoc_pkg::frpoc_cnt_t elapsed_q;
	logic enter_rst;
	logic ap_take;
	logic wr_pend_q;
	logic [frpoc_pkg::ADDR_W-1:0] wr_addr_q;
	logic [31:0] hrdata_q;
	logic short_set;
	logic early_set;

	// recovery length for an interrupted operation
	function automatic frpoc_pkg::frpoc_cnt_t rec_cycles(input frpoc_pkg::frpoc_kind_t k);
		case (k)
			frpoc_pkg::K_DECODE: rec_cycles = frpoc_pkg::frpoc_cnt_t'(REC_DECODE_CYC);
			frpoc_pkg::K_READ: rec_cycles = frpoc_pkg::frpoc_cnt_t'(REC_READ_CYC);
			frpoc_pkg::K_PROGRAM: rec_cycles = frpoc_pkg::frpoc_cnt_t'(REC_PROGRAM_CYC);
			frpoc_pkg::K_SMALL_ERASE: rec_cycles = frpoc_pkg::frpoc_cnt_t'(REC_SMALL_CYC);
			frpoc_pkg::K_HALF_BLOCK: rec_cycles = frpoc_pkg::frpoc_cnt_t'(REC_BLOCK_CYC);
			frpoc_pkg::K_LARGE_BLOCK: rec_cycles = frpoc_pkg::frpoc_cnt_t'(REC_BLOCK_CYC);
			frpoc_pkg::K_CHIP_ERASE: rec_cycles = frpoc_pkg::frpoc_cnt_t'(REC_CHIP_CYC);
			frpoc_pkg::K_STATUS_WRITE: rec_cycles = frpoc_pkg::frpoc_cnt_t'(REC_STATUS_CYC);
			default: rec_cycles = frpoc_pkg::frpoc_cnt_t'(POR_REC_CYC);
		endcase
	endfunction

	// a suspended erase decides the recovery class
	function automatic frpoc_pkg::frpoc_kind_t eff_kind(input frpoc_pkg::frpoc_op_t op);
		eff_kind = op.erase_suspended ? op.suspended_kind : op.kind;
	endfunction

	// operations that change the array or status bits
	function automatic logic destructive(input frpoc_pkg::frpoc_kind_t k);
		destructive = (k == frpoc_pkg::K_PROGRAM) || (k == frpoc_pkg::K_SMALL_ERASE) ||
			(k == frpoc_pkg::K_HALF_BLOCK) || (k == frpoc_pkg::K_LARGE_BLOCK) ||
			(k == frpoc_pkg::K_CHIP_ERASE) || (k == frpoc_pkg::K_STATUS_WRITE);
	endfunction

	// pin synchronisers: reset, select, supply
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			sync1_q <= 3'h3;
			sync2_q <= 3'h3;
		end else begin
			sync1_q <= {SUPPLY_OK, CS_N, RESET_N};
			sync2_q <= sync1_q;
		end
	end

	assign rst_pin_low = ~sync2_q[0];
	assign cs_low = ~sync2_q[1];
	assign supply_ok_s = sync2_q[2];
	assign rst_low = rst_pin_low | ctrl_force_q;

	// reset pulse width meter
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			rst_low_q <= 1'h0;
		end else begin
			rst_low_q <= rst_low;
		end
	end

	assign pulse_load = rst_low & ~rst_low_q;

	frpoc_timer u_pulse (
		.clk(CLK),
		.rst(SYS_RST),
		.load(pulse_load),
		.load_val(frpoc_pkg::frpoc_cnt_t'(frpoc_pkg::RESET_LOW_PULSE_MIN_CYC - 1)),
		.done(pulse_done)
	);

	// start-up and recovery timer
	assign enter_rst = supply_ok_s & rst_low &
		((state_q == frpoc_pkg::ST_READY) || (state_q == frpoc_pkg::ST_POWERUP) ||
		(state_q == frpoc_pkg::ST_RECOVER));
	assign req_cyc = rec_cycles(kind_q);

	always_comb begin
		tmr_load = 1'h0;
		tmr_val = req_cyc;
		if ((state_q == frpoc_pkg::ST_POR) && supply_ok_s) begin
			tmr_load = 1'h1;
			tmr_val = frpoc_pkg::frpoc_cnt_t'(SUPPLY_SEL_CYC);
		end else if ((state_q == frpoc_pkg::ST_RESET) && supply_ok_s && !rst_low) begin
			tmr_load = 1'h1;
		end
	end

	frpoc_timer u_rec (
		.clk(CLK),
		.rst(SYS_RST),
		.load(tmr_load),
		.load_val(tmr_val),
		.done(tmr_done)
	);

	// state sequence
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			state_q <= frpoc_pkg::ST_POR;
		end else if (!supply_ok_s) begin
			state_q <= frpoc_pkg::ST_POR;
		end else begin
			case (state_q)
				frpoc_pkg::ST_POR: begin
					state_q <= frpoc_pkg::ST_POWERUP;
				end
				frpoc_pkg::ST_POWERUP: begin
					if (rst_low) begin
						state_q <= frpoc_pkg::ST_RESET;
					end else if (tmr_done) begin
						state_q <= frpoc_pkg::ST_READY;
					end
				end
				frpoc_pkg::ST_READY: begin
					if (rst_low) begin
						state_q <= frpoc_pkg::ST_RESET;
					end
				end
				frpoc_pkg::ST_RESET: begin
					if (!rst_low) begin
						state_q <= frpoc_pkg::ST_RECOVER;
					end
				end
				frpoc_pkg::ST_RECOVER: begin
					if (rst_low) begin
						state_q <= frpoc_pkg::ST_RESET;
					end else if (tmr_done) begin
						state_q <= frpoc_pkg::ST_READY;
					end
				end
				default: state_q <= frpoc_pkg::ST_POR;
			endcase
		end
	end

	// class of the interrupted operation
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			kind_q <= frpoc_pkg::K_IDLE;
		end else if (enter_rst && (state_q == frpoc_pkg::ST_READY)) begin
			kind_q <= eff_kind(OP_STAT);
		end else if (enter_rst && (state_q == frpoc_pkg::ST_POWERUP)) begin
			kind_q <= frpoc_pkg::K_IDLE;
		end
	end

	// abort pulse for a running program or erase
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			abort_q <= 1'h0;
		end else begin
			abort_q <= enter_rst && (state_q == frpoc_pkg::ST_READY) &&
				destructive(eff_kind(OP_STAT));
		end
	end

	// controls to the flash core
	always_comb begin
		CTL.core_rst = (state_q == frpoc_pkg::ST_POR) || (state_q == frpoc_pkg::ST_RESET);
		CTL.abort = abort_q;
		CTL.so_allow = !CTL.core_rst;
		CTL.low_power = CTL.core_rst;
		CTL.read_ok = (state_q == frpoc_pkg::ST_READY);
		CTL.write_ok = (state_q == frpoc_pkg::ST_READY);
	end

	// host timing faults seen at the pins
	assign short_set = (state_q == frpoc_pkg::ST_RESET) && !rst_low && !pulse_done;
	assign early_set = cs_low && ((state_q == frpoc_pkg::ST_POWERUP) ||
		(state_q == frpoc_pkg::ST_RESET) || (state_q == frpoc_pkg::ST_RECOVER));

	// ahb-lite slave, zero wait states
	assign ap_take = HSEL && HREADY && (HTRANS == frpoc_pkg::HTRANS_NONSEQ);
	assign HREADYOUT = 1'h1;
	assign HRESP = frpoc_pkg::HRESP_OKAY;
	assign HRDATA = hrdata_q;

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			wr_pend_q <= 1'h0;
			wr_addr_q <= '0;
		end else begin
			wr_pend_q <= ap_take && HWRITE && (HADDR[31:frpoc_pkg::ADDR_W] == '0);
			wr_addr_q <= HADDR[frpoc_pkg::ADDR_W-1:0];
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			hrdata_q <= 32'h0;
		end else if (ap_take && !HWRITE) begin
			hrdata_q <= 32'h0;
			if (HADDR[31:frpoc_pkg::ADDR_W] == '0) begin
				case (HADDR[frpoc_pkg::ADDR_W-1:0])
					frpoc_pkg::REG_CTRL: hrdata_q[frpoc_pkg::CTRL_FORCE_BIT] <= ctrl_force_q;
					frpoc_pkg::REG_STATUS: begin
						hrdata_q[frpoc_pkg::STAT_STATE_LSB +: 3] <= state_q;
						hrdata_q[frpoc_pkg::STAT_KIND_LSB +: 4] <= kind_q;
						hrdata_q[frpoc_pkg::STAT_SHORT_BIT] <= short_q;
						hrdata_q[frpoc_pkg::STAT_EARLY_BIT] <= early_q;
						hrdata_q[frpoc_pkg::STAT_READY_BIT] <= CTL.read_ok;
					end
					frpoc_pkg::REG_RST_COUNT: hrdata_q[frpoc_pkg::RST_COUNT_W-1:0] <= rst_cnt_q;
					default: hrdata_q <= 32'h0;
				endcase
			end
		end
	end

	// software reset request
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			ctrl_force_q <= 1'h0;
		end else if (wr_pend_q && (wr_addr_q == frpoc_pkg::REG_CTRL)) begin
			ctrl_force_q <= HWDATA[frpoc_pkg::CTRL_FORCE_BIT];
		end
	end

	// sticky fault flags, write one to clear, set wins
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			short_q <= 1'h0;
			early_q <= 1'h0;
		end else begin
			if (short_set) begin
				short_q <= 1'h1;
			end else if (wr_pend_q && (wr_addr_q == frpoc_pkg::REG_STATUS) &&
				HWDATA[frpoc_pkg::STAT_SHORT_BIT]) begin
				short_q <= 1'h0;
			end
			if (early_set) begin
				early_q <= 1'h1;
			end else if (wr_pend_q && (wr_addr_q == frpoc_pkg::REG_STATUS) &&
				HWDATA[frpoc_pkg::STAT_EARLY_BIT]) begin
				early_q <= 1'h0;
			end
		end
	end

	// count of resets taken
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			rst_cnt_q <= '0;
		end else if (enter_rst) begin
			rst_cnt_q <= rst_cnt_q + 1'b1;
		end
	end

	// cycles spent in recovery, for checking
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			elapsed_q <= '0;
		end else if (state_q == frpoc_pkg::ST_RECOVER) begin
			elapsed_q <= elapsed_q + 1'b1;
		end else begin
			elapsed_q <= '0;
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	property p_short_pulse;
		(state_q == frpoc_pkg::ST_RESET && !rst_low && !pulse_done) |=> short_q;
	endproperty
	a_short_pulse: assert property (p_short_pulse) else $error("short reset pulse not flagged");

	property p_reset_clears;
		(state_q == frpoc_pkg::ST_RESET) |-> CTL.core_rst && !CTL.read_ok && !CTL.write_ok;
	endproperty
	a_reset_clears: assert property (p_reset_clears) else $error("core not held in reset");

	property p_abort;
		(state_q == frpoc_pkg::ST_READY && rst_low && supply_ok_s &&
			destructive(eff_kind(OP_STAT))) |=> CTL.abort && state_q == frpoc_pkg::ST_RESET
			##1 !CTL.abort;
	endproperty
	a_abort: assert property (p_abort) else $error("abort pulse missing or too long");

	property p_so_off;
		(state_q == frpoc_pkg::ST_RESET) |-> !CTL.so_allow && CTL.low_power;
	endproperty
	a_so_off: assert property (p_so_off) else $error("output not off during reset");

	property p_rec_min;
		(state_q == frpoc_pkg::ST_RECOVER ##1 state_q == frpoc_pkg::ST_READY) |->
			$past(elapsed_q) >= $past(req_cyc);
	endproperty
	a_rec_min: assert property (p_rec_min) else $error("recovery ended early");

	property p_rec_max;
		(state_q == frpoc_pkg::ST_RECOVER) |-> elapsed_q <= req_cyc;
	endproperty
	a_rec_max: assert property (p_rec_max) else $error("recovery ran too long");

	property p_por_kind;
		(state_q == frpoc_pkg::ST_POWERUP && rst_low && supply_ok_s) |=>
			kind_q == frpoc_pkg::K_IDLE && req_cyc == frpoc_pkg::frpoc_cnt_t'(POR_REC_CYC);
	endproperty
	a_por_kind: assert property (p_por_kind) else $error("power-on recovery class wrong");

	property p_suspend;
		(state_q == frpoc_pkg::ST_READY && rst_low && supply_ok_s && OP_STAT.erase_suspended)
			|=> kind_q == $past(OP_STAT.suspended_kind);
	endproperty
	a_suspend: assert property (p_suspend) else $error("suspended erase class ignored");

	property p_powerup;
		(state_q == frpoc_pkg::ST_POR && supply_ok_s) |=> state_q == frpoc_pkg::ST_POWERUP;
	endproperty
	a_powerup: assert property (p_powerup) else $error("power-up did not enter start-up");

	property p_por_hold;
		!supply_ok_s |=> CTL.core_rst && !CTL.read_ok && !CTL.write_ok;
	endproperty
	a_por_hold: assert property (p_por_hold) else $error("logic not held below threshold");

	property p_ready_src;
		$rose(CTL.read_ok) |-> $past(tmr_done) &&
			($past(state_q) == frpoc_pkg::ST_POWERUP || $past(state_q) == frpoc_pkg::ST_RECOVER);
	endproperty
	a_ready_src: assert property (p_ready_src) else $error("ready before delay expired");
endmodule // frpoc_top

// file: testbench/frpoc_host.sv
`timescale 1ns/1ps
module frpoc_host (
	// clock
	input wire logic clk,
	// command from bench
	input wire logic start,
	input wire logic [31:0] low_cyc,
	input wire logic [31:0] wait_cyc,
	// pins
	output logic reset_n,
	output logic cs_n,
	output logic busy
);
	initial begin
		reset_n = 1'b1;
		cs_n = 1'b1;
		busy = 1'b0;
	end
	// one reset pulse, a wait, then a short select
	always @(posedge clk) begin
		if (start && !busy) begin
			busy <= 1'b1;
			reset_n <= 1'b0;
			repeat (low_cyc) @(posedge clk);
			reset_n <= 1'b1;
			repeat (wait_cyc) @(posedge clk);
			cs_n <= 1'b0;
			repeat (4) @(posedge clk);
			cs_n <= 1'b1;
			busy <= 1'b0;
		end
	end
endmodule // frpoc_host

// file: testbench/frpoc_tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; \
	$display("ERROR %0t: mismatch got %0h exp %0h", $time, (g), (e)); end end
module frpoc_tb_top;
	localparam int P_POR = 40;
	localparam int P_SUP = 50;
	localparam int SEL = frpoc_pkg::RESET_TO_SELECT_DELAY_CYC;
	localparam int REC[9] = '{40, 60, 45, 100, 150, 200, 200, 300, 250};
	logic CLK = 1'b0;
	logic SYS_RST = 1'b1;
	logic SUPPLY_OK = 1'b0;
	logic RESET_N;
	logic CS_N;
	frpoc_pkg::frpoc_op_t OP_STAT = '0;
	frpoc_pkg::frpoc_ctl_t CTL;
	logic HSEL = 1'b1;
	logic [31:0] HADDR = '0;
	logic [1:0] HTRANS = 2'h0;
	logic HWRITE = 1'b0;
	logic [31:0] HWDATA = '0;
	logic [31:0] HRDATA;
	logic HREADYOUT;
	logic HRESP;
	logic go = 1'b0;
	logic [31:0] lo_len = 32'h0;
	logic [31:0] wt_len = 32'h0;
	logic busy;
	int bad_count = 0;
	int check_count = 0;
	int cyc = 0;
	int abort_n = 0;
	always #2.5 CLK = ~CLK;
	frpoc_top #(.POR_REC_CYC(REC[0]), .REC_DECODE_CYC(REC[1]), .REC_READ_CYC(REC[2]),
		.REC_PROGRAM_CYC(REC[3]), .REC_SMALL_CYC(REC[4]), .REC_BLOCK_CYC(REC[5]),
		.REC_CHIP_CYC(REC[7]), .REC_STATUS_CYC(REC[8]),
		.SUPPLY_SEL_CYC(P_SUP)) uut (.CLK(CLK), .SYS_RST(SYS_RST), .RESET_N(RESET_N),
		.CS_N(CS_N), .SUPPLY_OK(SUPPLY_OK), .OP_STAT(OP_STAT), .CTL(CTL), .HSEL(HSEL),
		.HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
		.HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP));
	frpoc_host host (.clk(CLK), .start(go), .low_cyc(lo_len), .wait_cyc(wt_len),
		.reset_n(RESET_N), .cs_n(CS_N), .busy(busy));
	always @(posedge CLK) begin
		cyc++;
		if (CTL.abort === 1'b1) begin
			abort_n++;
		end
		if (cyc == 90000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	task tally_and_finish;
		$display("checks %0d errors %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// single word transfer, waits on the ready handshake
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		HADDR <= a;
		HWRITE <= wr;
		HTRANS <= frpoc_pkg::HTRANS_NONSEQ;
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		HTRANS <= 2'h0;
		HWDATA <= wd;
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		rd = HRDATA;
		`CHK(HRESP, frpoc_pkg::HRESP_OKAY)
	endtask
	task automatic wait_ready(output int n);
		n = 0;
		while (CTL.read_ok !== 1'b1) begin
			@(posedge CLK);
			n++;
		end
	endtask
	// pulse reset with a given operation reported, measure recovery
	task automatic do_reset(input logic [3:0] k, input logic susp, input int lo, input int wt,
		input int rec, output logic [31:0] s);
		int a0;
		int n;
		OP_STAT <= {susp, frpoc_pkg::K_CHIP_ERASE, k};
		a0 = abort_n;
		lo_len <= lo;
		wt_len <= wt;
		go <= 1'b1;
		@(posedge CLK);
		go <= 1'b0;
		repeat (10) @(posedge CLK);
		`CHK(CTL.core_rst, 1'b1)
		`CHK(CTL.so_allow, 1'b0)
		`CHK(CTL.low_power, 1'b1)
		`CHK(CTL.read_ok, 1'b0)
		while (RESET_N !== 1'b1) @(posedge CLK);
		OP_STAT <= '0;
		`CHK(abort_n, a0 + ((k >= 3 || susp) ? 1 : 0))
		wait_ready(n);
		`CHK(n >= rec + 2 && n <= rec + 6, 1'b1)
		`CHK(CTL.write_ok, 1'b1)
		`CHK(CTL.core_rst, 1'b0)
		while (busy !== 1'b0) @(posedge CLK);
		ahb(1'b0, frpoc_pkg::REG_STATUS, 32'h0, s);
		`CHK(s[2:0], 3'h2)
		`CHK(s[7:4], susp ? 4'h7 : k)
		`CHK(s[10], 1'b1)
	endtask
	task automatic t_powerup;
		logic [31:0] s;
		int n;
		int a0;
		repeat (10) @(posedge CLK);
		ahb(1'b0, frpoc_pkg::REG_STATUS, 32'h0, s);
		`CHK(s[2:0], 3'h0)
		`CHK(CTL.core_rst, 1'b1)
		`CHK(CTL.read_ok, 1'b0)
		SUPPLY_OK <= 1'b1;
		wait_ready(n);
		`CHK(n >= P_SUP + 1 && n <= P_SUP + 6, 1'b1)
		`CHK(CTL.low_power, 1'b0)
		`CHK(CTL.write_ok, 1'b1)
		SUPPLY_OK <= 1'b0;
		repeat (6) @(posedge CLK);
		`CHK(CTL.core_rst, 1'b1)
		`CHK(CTL.write_ok, 1'b0)
		// reset pin pulled during start-up: power-on recovery, no abort
		OP_STAT <= {1'b0, frpoc_pkg::K_CHIP_ERASE, frpoc_pkg::K_PROGRAM};
		SUPPLY_OK <= 1'b1;
		a0 = abort_n;
		lo_len <= 32'd2000;
		wt_len <= 32'(SEL + P_POR + 10);
		repeat (10) @(posedge CLK);
		go <= 1'b1;
		@(posedge CLK);
		go <= 1'b0;
		repeat (10) @(posedge CLK);
		`CHK(CTL.core_rst, 1'b1)
		while (RESET_N !== 1'b1) @(posedge CLK);
		wait_ready(n);
		`CHK(n >= P_POR + 2 && n <= P_POR + 6, 1'b1)
		while (busy !== 1'b0) @(posedge CLK);
		OP_STAT <= '0;
		ahb(1'b0, frpoc_pkg::REG_STATUS, 32'h0, s);
		`CHK(s[7:4], 4'h0)
		`CHK(abort_n, a0)
	endtask
	task automatic t_kinds;
		logic [31:0] s;
		for (int k = 0; k < 9; k++) begin
			do_reset(k[3:0], 1'b0, 2000, SEL + REC[k] + 10, REC[k], s);
			`CHK(s[9:8], 2'h0)
		end
		do_reset(4'h2, 1'b1, 2000, SEL + 310, REC[7], s);
	endtask
	task automatic t_short_early;
		logic [31:0] s;
		do_reset(4'h1, 1'b0, 100, 5, REC[1], s);
		`CHK(s[9:8], 2'h3)
		ahb(1'b1, frpoc_pkg::REG_STATUS, 32'h300, s);
		ahb(1'b0, frpoc_pkg::REG_STATUS, 32'h0, s);
		`CHK(s[9:8], 2'h0)
	endtask
	task automatic t_regs;
		logic [31:0] s;
		logic [31:0] c0;
		int n;
		ahb(1'b0, 32'hC, 32'h0, s);
		`CHK(s, 32'h0)
		ahb(1'b0, 32'h100, 32'h0, s);
		`CHK(s, 32'h0)
		ahb(1'b0, frpoc_pkg::REG_RST_COUNT, 32'h0, c0);
		ahb(1'b1, frpoc_pkg::REG_RST_COUNT, 32'hFFFF, s);
		ahb(1'b1, frpoc_pkg::REG_CTRL, 32'h1, s);
		repeat (5) @(posedge CLK);
		`CHK(CTL.core_rst, 1'b1)
		ahb(1'b0, frpoc_pkg::REG_STATUS, 32'h0, s);
		`CHK(s[2:0], 3'h3)
		ahb(1'b1, frpoc_pkg::REG_CTRL, 32'h0, s);
		wait_ready(n);
		`CHK(n >= P_POR && n <= P_POR + 8, 1'b1)
		ahb(1'b0, frpoc_pkg::REG_RST_COUNT, 32'h0, s);
		`CHK(s, c0 + 32'h1)
	endtask
	initial begin
		repeat (3) @(posedge CLK);
		SYS_RST <= 1'b0;
		t_powerup();
		t_kinds();
		t_short_early();
		t_regs();
		tally_and_finish();
	end
endmodule // frpoc_tb_top
